// ==== mmd_decoder.sv ====
`timescale 1ns/1ps
// Behaviour
// RULE1: 8k space with 64-byte register area
// RULE2: 0x0000-0x003F routes to register area
// RULE3: unimplemented bits read undefined, writes ignored
// RULE4: 144-byte RAM at 0x0080-0x012F
// RULE5: stack 0x00FF down to 0x00C0
// RULE6: user ROM at 0x1400-0x1DFF
// RULE7: vector ROM at 0x1FF0-0x1FFF
// RULE8: self-check ROM at 0x1E00-0x1FEF
// RULE9: reset makes all port lines inputs
// RULE10: unused locations read undefined, ignore writes
// RULE11: pull registers write-only, read undefined
module mmd_decoder
  import mmd_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // CPU bus
  input  wire mmd_pkg::mmd_addr_t   cpu_addr,
  input  wire logic                 cpu_rd,
  input  wire logic                 cpu_wr,
  input  wire mmd_pkg::mmd_data_t   cpu_wdata,
  output mmd_pkg::mmd_data_t        cpu_rdata,
  // ROM side
  output mmd_pkg::mmd_addr_t        rom_addr,
  output logic                      rom_user_sel,
  output logic                      rom_vec_sel,
  output logic                      rom_chk_sel,
  input  wire mmd_pkg::mmd_data_t   rom_rdata,
  // Status
  output logic                      stack_hit,
  // Pins and peripherals
  input  wire mmd_pkg::mmd_data_t   pa_pins,
  input  wire mmd_pkg::mmd_data_t   pb_pins,
  input  wire mmd_pkg::mmd_data_t   pc_pins,
  input  wire mmd_pkg::mmd_periph_s periph,
  output mmd_pkg::mmd_regs_s        regs,
  output logic                      mft_flag_clr,
  output logic                      ext_flag_clr
);
  import mmd_pkg::*;

  mmd_state_s state_q;
  mmd_state_s state_d;
  mmd_regs_s  st_q;
  mmd_regs_s  st_d;
  mmd_sel_e   sel;
  mmd_sel_e   sel_q;
  logic       ram_we;
  logic       ram_in;
  logic       rom_any;
  mmd_data_t  ram_rdata;
  logic [RAM_AW-1:0] ram_addr;

  // Register file and read route live in one state word
  assign st_q  = state_q.regs;
  assign sel_q = state_q.rd_sel;

  assign rom_user_sel = (cpu_addr >= ROM_LO) && (cpu_addr <= ROM_HI); // RULE6
  assign rom_chk_sel  = (cpu_addr >= CHK_LO) && (cpu_addr <= CHK_HI); // RULE8
  assign rom_vec_sel  = (cpu_addr >= VEC_LO) && (cpu_addr <= VEC_HI); // RULE7
  assign rom_any      = rom_user_sel || rom_chk_sel || rom_vec_sel;
  // ROM sees the raw address and registers it itself, like the RAM read
  assign rom_addr     = cpu_addr;
  // Stack shares the RAM array; flagged so software can watch for overlap
  assign stack_hit    = (cpu_addr >= STACK_BOT) && (cpu_addr <= STACK_TOP); // RULE5

  always_comb
  begin
    // 13-bit address covers exactly the 8k space
    if (cpu_addr <= IO_HI) // RULE1
    begin
      sel = MMD_SEL_IO; // RULE2
    end
    else if ((cpu_addr >= RAM_LO) && (cpu_addr <= RAM_HI))
    begin
      sel = MMD_SEL_RAM; // RULE4
    end
    else if (rom_any)
    begin
      sel = MMD_SEL_ROM;
    end
    else
    begin
      sel = MMD_SEL_NONE;
    end
  end

  // The span holds more bytes than the array; bytes past its top drop writes
  // and read undefined rather than touching a missing word
  assign ram_addr = RAM_AW'(cpu_addr - RAM_LO);
  assign ram_in   = ram_addr < RAM_AW'(RAM_DEPTH);
  assign ram_we   = cpu_wr && (sel == MMD_SEL_RAM) && ram_in; // RULE4

  mmd_ram u_ram (
    .clk   (clk),
    .we    (ram_we),
    .addr  (ram_addr),
    .wdata (cpu_wdata),
    .rdata (ram_rdata)
  );

  // Flag clears are write-one strobes passed to the peripheral
  // The peripheral picks the clear bits out of the write data itself
  assign mft_flag_clr = cpu_wr && (sel == MMD_SEL_IO) && (cpu_addr == OFS_MFT_CF);
  assign ext_flag_clr = cpu_wr && (sel == MMD_SEL_IO) && (cpu_addr == OFS_EXT_CF);

  always_comb
  begin
    st_d = st_q;
    // Write-one clear bits are stored in mft_cf and ext_cf as well as sent on the strobes above
    if (cpu_wr && (sel == MMD_SEL_IO))
    begin
      // Only implemented bits take the write
      if (cpu_addr == OFS_PA_VAL)
      begin
        st_d.pa_val = cpu_wdata;
      end
      else if (cpu_addr == OFS_PB_VAL)
      begin
        st_d.pb_val = cpu_wdata & MSK_PB; // RULE3
      end
      else if (cpu_addr == OFS_PC_VAL)
      begin
        st_d.pc_val = cpu_wdata & MSK_PC; // RULE3
      end
      else if (cpu_addr == OFS_PA_DIR)
      begin
        st_d.pa_dir = cpu_wdata;
      end
      else if (cpu_addr == OFS_PB_DIR)
      begin
        st_d.pb_dir = cpu_wdata;
      end
      else if (cpu_addr == OFS_PC_DIR)
      begin
        st_d.pc_dir = cpu_wdata & MSK_PCDIR; // RULE3
      end
      else if (cpu_addr == OFS_MFT_CF)
      begin
        st_d.mft_cf = cpu_wdata & MSK_MFT_W; // RULE3
      end
      else if (cpu_addr == OFS_EXT_CF)
      begin
        st_d.ext_cf = cpu_wdata & MSK_EXT_W; // RULE3
      end
      else if (cpu_addr == OFS_OPT_EN)
      begin
        st_d.opt_en = cpu_wdata;
      end
      else if (cpu_addr == OFS_PC_PULL)
      begin
        st_d.pc_pull = cpu_wdata & MSK_PC; // RULE11
      end
      else if (cpu_addr == OFS_PA_PULL)
      begin
        st_d.pa_pull = cpu_wdata; // RULE11
      end
      else if (cpu_addr == OFS_PB_PULL)
      begin
        st_d.pb_pull = cpu_wdata & MSK_PBPULL; // RULE11
      end
      else if (cpu_addr == OFS_WT_CTRL)
      begin
        st_d.wt_ctrl = cpu_wdata & MSK_WT_W; // RULE3
      end
      else if (cpu_addr == OFS_CMP_H)
      begin
        st_d.cmp_h = cpu_wdata;
      end
      else if (cpu_addr == OFS_CMP_L)
      begin
        st_d.cmp_l = cpu_wdata;
      end
      // Unused and read-only locations keep no state
    end
    // Register read data; a port bit set as output reads its latch
    st_d.rdata = UNDEF_B; // RULE10
    if (cpu_rd && (sel == MMD_SEL_IO))
    begin
      if (cpu_addr == OFS_PA_VAL)
      begin
        st_d.rdata = (st_q.pa_val & st_q.pa_dir) | (pa_pins & ~st_q.pa_dir);
      end
      else if (cpu_addr == OFS_PB_VAL)
      begin
        st_d.rdata = ((st_q.pb_val & st_q.pb_dir) | (pb_pins & ~st_q.pb_dir)) & MSK_PB; // RULE3
      end
      else if (cpu_addr == OFS_PC_VAL)
      begin
        st_d.rdata = ((st_q.pc_val & st_q.pc_dir) | (pc_pins & ~st_q.pc_dir)) & MSK_PC; // RULE3
      end
      else if (cpu_addr == OFS_PA_DIR)
      begin
        st_d.rdata = st_q.pa_dir;
      end
      else if (cpu_addr == OFS_PB_DIR)
      begin
        st_d.rdata = st_q.pb_dir;
      end
      else if (cpu_addr == OFS_PC_DIR)
      begin
        st_d.rdata = st_q.pc_dir;
      end
      else if (cpu_addr == OFS_MFT_CF)
      begin
        st_d.rdata = periph.mft_flg | (st_q.mft_cf & MSK_MFT_W);
      end
      else if (cpu_addr == OFS_MFT_CNT)
      begin
        st_d.rdata = periph.mft_cnt;
      end
      else if (cpu_addr == OFS_EXT_CF)
      begin
        st_d.rdata = periph.ext_flg | st_q.ext_cf;
      end
      else if (cpu_addr == OFS_OPT_EN)
      begin
        st_d.rdata = st_q.opt_en;
      end
      else if (cpu_addr == OFS_WT_CTRL)
      begin
        st_d.rdata = st_q.wt_ctrl;
      end
      else if (cpu_addr == OFS_WT_FLG)
      begin
        st_d.rdata = periph.wt_flg;
      end
      else if (cpu_addr == OFS_CAP_H)
      begin
        st_d.rdata = periph.cap_h;
      end
      else if (cpu_addr == OFS_CAP_L)
      begin
        st_d.rdata = periph.cap_l;
      end
      else if (cpu_addr == OFS_CMP_H)
      begin
        st_d.rdata = st_q.cmp_h;
      end
      else if (cpu_addr == OFS_CMP_L)
      begin
        st_d.rdata = st_q.cmp_l;
      end
      else if (cpu_addr == OFS_WT_CH)
      begin
        st_d.rdata = periph.wt_ch;
      end
      else if (cpu_addr == OFS_WT_CL)
      begin
        st_d.rdata = periph.wt_cl;
      end
      else if (cpu_addr == OFS_ALT_H)
      begin
        st_d.rdata = periph.alt_h;
      end
      else if (cpu_addr == OFS_ALT_L)
      begin
        st_d.rdata = periph.alt_l;
      end
      // Pull registers and unused slots fall through to the default
    end

    // Only a read arms the output mux for the next cycle
    state_d.regs   = st_d;
    state_d.rd_sel = MMD_SEL_NONE;
    if (cpu_rd && ((sel != MMD_SEL_RAM) || ram_in))
    begin
      state_d.rd_sel = sel;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      // Directions clear with the rest, so no pin drives out of reset
      state_q             <= '0;
      state_q.regs.pa_dir <= DIR_RST; // RULE9
      state_q.regs.pb_dir <= DIR_RST; // RULE9
      state_q.regs.pc_dir <= DIR_RST; // RULE9
      state_q.rd_sel      <= MMD_SEL_NONE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Read data one cycle after the strobe; ROM is expected to answer in that cycle too
  // Idle and unmapped cycles show zero so no stale byte leaks onto the bus
  always_comb
  begin
    case (sel_q)
      MMD_SEL_IO:   cpu_rdata = st_q.rdata;
      MMD_SEL_RAM:  cpu_rdata = ram_rdata;
      MMD_SEL_ROM:  cpu_rdata = rom_rdata;
      default:      cpu_rdata = ZERO_B;
    endcase
  end

  assign regs = st_q;
endmodule

// ==== mmd_pkg.sv ====
package mmd_pkg;
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned RAM_DEPTH = 144;
  localparam int unsigned RAM_AW = 8;
  typedef logic [ADDR_W-1:0] mmd_addr_t;
  typedef logic [DATA_W-1:0] mmd_data_t;
  localparam mmd_addr_t IO_LO       = 13'h0000;
  localparam mmd_addr_t IO_HI       = 13'h003F;
  localparam mmd_addr_t RAM_LO      = 13'h0080;
  localparam mmd_addr_t RAM_HI      = 13'h012F;
  localparam mmd_addr_t STACK_TOP   = 13'h00FF;
  localparam mmd_addr_t STACK_BOT   = 13'h00C0;
  localparam mmd_addr_t ROM_LO      = 13'h1400;
  localparam mmd_addr_t ROM_HI      = 13'h1DFF;
  localparam mmd_addr_t CHK_LO      = 13'h1E00;
  localparam mmd_addr_t CHK_HI      = 13'h1FEF;
  localparam mmd_addr_t VEC_LO      = 13'h1FF0;
  localparam mmd_addr_t VEC_HI      = 13'h1FFF;
  localparam mmd_addr_t OFS_PA_VAL  = 13'h0000;
  localparam mmd_addr_t OFS_PB_VAL  = 13'h0001;
  localparam mmd_addr_t OFS_PC_VAL  = 13'h0002;
  localparam mmd_addr_t OFS_PA_DIR  = 13'h0004;
  localparam mmd_addr_t OFS_PB_DIR  = 13'h0005;
  localparam mmd_addr_t OFS_PC_DIR  = 13'h0006;
  localparam mmd_addr_t OFS_MFT_CF  = 13'h0008;
  localparam mmd_addr_t OFS_MFT_CNT = 13'h0009;
  localparam mmd_addr_t OFS_EXT_CF  = 13'h000A;
  localparam mmd_addr_t OFS_OPT_EN  = 13'h000E;
  localparam mmd_addr_t OFS_PC_PULL = 13'h000F;
  localparam mmd_addr_t OFS_PA_PULL = 13'h0010;
  localparam mmd_addr_t OFS_PB_PULL = 13'h0011;
  localparam mmd_addr_t OFS_WT_CTRL = 13'h0012;
  localparam mmd_addr_t OFS_WT_FLG  = 13'h0013;
  localparam mmd_addr_t OFS_CAP_H   = 13'h0014;
  localparam mmd_addr_t OFS_CAP_L   = 13'h0015;
  localparam mmd_addr_t OFS_CMP_H   = 13'h0016;
  localparam mmd_addr_t OFS_CMP_L   = 13'h0017;
  localparam mmd_addr_t OFS_WT_CH   = 13'h0018;
  localparam mmd_addr_t OFS_WT_CL   = 13'h0019;
  localparam mmd_addr_t OFS_ALT_H   = 13'h001A;
  localparam mmd_addr_t OFS_ALT_L   = 13'h001B;
  localparam mmd_data_t DIR_RST     = 8'h00;
  localparam mmd_data_t ZERO_B      = 8'h00;
  localparam mmd_data_t UNDEF_B     = 8'h00;
  // Implemented bit masks per register
  localparam mmd_data_t MSK_PB      = 8'hF7;
  localparam mmd_data_t MSK_PC      = 8'h0F;
  localparam mmd_data_t MSK_PCDIR   = 8'hCF;
  localparam mmd_data_t MSK_MFT_W   = 8'h33;
  localparam mmd_data_t MSK_EXT_W   = 8'h81;
  localparam mmd_data_t MSK_WT_W    = 8'hE2;
  localparam mmd_data_t MSK_PBPULL  = 8'hF7;
  typedef enum logic [1:0] {
    MMD_SEL_NONE = 2'b00,
    MMD_SEL_IO   = 2'b01,
    MMD_SEL_RAM  = 2'b10,
    MMD_SEL_ROM  = 2'b11
  } mmd_sel_e;
  typedef struct packed {
    mmd_data_t pa_val;
    mmd_data_t pb_val;
    mmd_data_t pc_val;
    mmd_data_t pa_dir;
    mmd_data_t pb_dir;
    mmd_data_t pc_dir;
    mmd_data_t mft_cf;
    mmd_data_t ext_cf;
    mmd_data_t opt_en;
    mmd_data_t pa_pull;
    mmd_data_t pb_pull;
    mmd_data_t pc_pull;
    mmd_data_t wt_ctrl;
    mmd_data_t cmp_h;
    mmd_data_t cmp_l;
    mmd_data_t rdata;
  } mmd_regs_s;
  typedef struct packed {
    mmd_data_t mft_cnt;
    mmd_data_t wt_flg;
    mmd_data_t cap_h;
    mmd_data_t cap_l;
    mmd_data_t wt_ch;
    mmd_data_t wt_cl;
    mmd_data_t alt_h;
    mmd_data_t alt_l;
    mmd_data_t mft_flg;
    mmd_data_t ext_flg;
  } mmd_periph_s;
  typedef struct packed {
    mmd_regs_s regs;
    mmd_sel_e  rd_sel;
  } mmd_state_s;
endpackage

// ==== mmd_ram.sv ====
`timescale 1ns/1ps
module mmd_ram
  import mmd_pkg::*;
(
  // Clock
  input  wire logic                clk,
  // Access
  input  wire logic                we,
  input  wire logic [RAM_AW-1:0]   addr,
  input  wire mmd_pkg::mmd_data_t  wdata,
  output mmd_pkg::mmd_data_t       rdata
);
  mmd_data_t mem [RAM_DEPTH];
  // Contents carry no reset, as for any plain RAM
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// ==== mmd_decoder_sva.sv ====
`timescale 1ns/1ps
module mmd_decoder_sva
  import mmd_pkg::*;
(
  // Clock and reset
  input wire logic               clk,
  input wire logic               rst,
  // CPU bus
  input wire mmd_pkg::mmd_addr_t cpu_addr,
  input wire logic               cpu_rd,
  input wire logic               cpu_wr,
  input wire mmd_pkg::mmd_data_t cpu_wdata,
  input wire mmd_pkg::mmd_data_t cpu_rdata,
  // Memory side and status
  input wire mmd_pkg::mmd_addr_t rom_addr,
  input wire logic               rom_user_sel,
  input wire logic               rom_vec_sel,
  input wire logic               rom_chk_sel,
  input wire mmd_pkg::mmd_data_t rom_rdata,
  input wire logic               stack_hit,
  input wire mmd_pkg::mmd_regs_s regs
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  addr_pass_a: assert property (rom_addr == cpu_addr)
    else $error("rom address differs from cpu address");
  user_rom_a: assert property (rom_user_sel == (cpu_addr inside {[ROM_LO:ROM_HI]}))
    else $error("user rom select wrong");
  vec_rom_a: assert property (rom_vec_sel == (cpu_addr inside {[VEC_LO:VEC_HI]}))
    else $error("vector select wrong");
  chk_rom_a: assert property (rom_chk_sel == (cpu_addr inside {[CHK_LO:CHK_HI]}))
    else $error("self-check select wrong");
  stack_span_a: assert property (stack_hit == (cpu_addr inside {[STACK_BOT:STACK_TOP]}))
    else $error("stack hit wrong");
  dir_write_a: assert property (cpu_wr && cpu_addr == OFS_PA_DIR |=> regs.pa_dir == $past(cpu_wdata))
    else $error("direction write lost");
  pc_mask_a: assert property (cpu_wr && cpu_addr == OFS_PC_VAL |=> (regs.pc_val & ~MSK_PC) == ZERO_B)
    else $error("unimplemented bit stored");
  unused_rd_a: assert property (cpu_rd && cpu_addr inside {13'h0003, 13'h0007, [13'h000B:13'h000D],
    [13'h001C:13'h001F]} |=> cpu_rdata == UNDEF_B)
    else $error("unused location read not undefined");
  pull_rd_a: assert property (cpu_rd && cpu_addr inside {[OFS_PC_PULL:OFS_PB_PULL]} |=> cpu_rdata == UNDEF_B)
    else $error("pull register readable");
  rom_rd_a: assert property (cpu_rd && cpu_addr inside {[ROM_LO:VEC_HI]} |=> cpu_rdata == rom_rdata)
    else $error("rom data not passed");
  hole_rd_a: assert property (cpu_rd && cpu_addr inside {[13'h0040:13'h007F], [13'h0130:13'h13FF]}
    |=> cpu_rdata == UNDEF_B)
    else $error("unmapped read not undefined");
  dir_reset_a: assert property ($fell(rst) |-> {regs.pa_dir, regs.pb_dir, regs.pc_dir} == 24'h000000)
    else $error("ports not inputs after reset");
endmodule
bind mmd_decoder mmd_decoder_sva u_sva (.clk, .rst, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata, .cpu_rdata,
  .rom_addr, .rom_user_sel, .rom_vec_sel, .rom_chk_sel, .rom_rdata, .stack_hit, .regs);

// ==== mmd_rom_model.sv ====
`timescale 1ns/1ps
module mmd_rom_model
  import mmd_pkg::*;
(
  // Clock
  input wire logic               clk,
  // Decoder side
  input wire mmd_pkg::mmd_addr_t addr,
  output mmd_pkg::mmd_data_t     rdata
);
  // Address-derived contents so a wrong route shows as wrong data
  always_ff @(posedge clk)
  begin
    rdata <= addr[7:0] ^ {3'h5, addr[12:8]};
  end
endmodule

// ==== mmd_decoder_tb_top.sv ====
`timescale 1ns/1ps
module mmd_decoder_tb_top;
  import mmd_pkg::*;
  logic       clk = 1'b0;
  logic       rst;
  mmd_addr_t  cpu_addr;
  logic       cpu_rd;
  logic       cpu_wr;
  mmd_data_t  cpu_wdata;
  mmd_data_t  cpu_rdata;
  mmd_addr_t  rom_addr;
  logic       usr;
  logic       vec;
  logic       sck;
  logic       stk;
  mmd_data_t  rom_rdata;
  mmd_data_t  pa_pins;
  mmd_regs_s  regs;
  mmd_data_t  pbc_pins;
  logic       mft_clr;
  logic       ext_clr;
  int         n_mft_clr = 0;
  int         n_ext_clr = 0;
  // Fixed peripheral values, distinct except the two zero flag bytes, so a wrong route shows
  mmd_periph_s periph = '{8'h91, 8'hA0, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97, 8'h98, 8'h00, 8'h00};
  int         n_mismatch = 0;
  int         checks_done = 0;
  always #5 clk = ~clk;
  // Strobes last one cycle, so they are counted at the edge that takes them
  always @(posedge clk)
  begin
    if (mft_clr)
      n_mft_clr <= n_mft_clr + 1;
    if (ext_clr)
      n_ext_clr <= n_ext_clr + 1;
  end
  mmd_decoder dut (.clk(clk), .rst(rst), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .rom_addr(rom_addr), .rom_user_sel(usr),
    .rom_vec_sel(vec), .rom_chk_sel(sck), .rom_rdata(rom_rdata), .stack_hit(stk), .pa_pins(pa_pins),
    .pb_pins(pbc_pins), .pc_pins(pbc_pins), .periph(periph), .regs(regs),
    .mft_flag_clr(mft_clr), .ext_flag_clr(ext_clr));
  mmd_rom_model rom (.clk(clk), .addr(rom_addr), .rdata(rom_rdata));
  task automatic chk(input logic [15:0] act, input logic [15:0] exp, input string what);
    checks_done++;
    if (act !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, act, exp);
    end
  endtask
  task automatic wr(input mmd_addr_t a, input mmd_data_t d);
    @(posedge clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge clk);
    cpu_wr <= 1'b0;
    #1;
  endtask
  // Read data lands one cycle after the strobe and stands for that cycle only
  task automatic rc(input mmd_addr_t a, input mmd_data_t exp);
    @(posedge clk);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge clk);
    cpu_rd <= 1'b0;
    #1;
    chk(cpu_rdata, exp, "read data");
  endtask
  task automatic t_reset_dirs;
    rc(OFS_PA_DIR, 8'h00);
    rc(OFS_PC_DIR, 8'h00);
    chk(regs.pb_dir, 8'h00, "dir b");
  endtask
  task automatic t_ports;
    @(posedge clk);
    pa_pins <= 8'h3C;
    wr(OFS_PA_VAL, 8'hA5);
    rc(OFS_PA_VAL, 8'h3C);
    wr(OFS_PA_DIR, 8'hFF);
    rc(OFS_PA_VAL, 8'hA5);
    wr(OFS_PC_DIR, 8'hFF);
    rc(OFS_PC_DIR, MSK_PCDIR);
    wr(OFS_PC_VAL, 8'hFF);
    chk(regs.pc_val, MSK_PC, "port c mask");
  endtask
  task automatic t_flags;
    wr(OFS_MFT_CF, 8'hFF);
    wr(OFS_EXT_CF, 8'hFF);
    chk({n_mft_clr[7:0], n_ext_clr[7:0]}, 16'h0101, "flag clear strobes");
    rc(OFS_MFT_CF, MSK_MFT_W);
    rc(OFS_EXT_CF, MSK_EXT_W);
    @(posedge clk);
    pbc_pins <= 8'hFF;
    rc(OFS_PB_VAL, MSK_PB);
    rc(OFS_PC_VAL, MSK_PC);
  endtask
  task automatic t_periph;
    mmd_addr_t a[8] = '{OFS_MFT_CNT, OFS_WT_FLG, OFS_CAP_H, OFS_CAP_L, OFS_WT_CH, OFS_WT_CL, OFS_ALT_H, OFS_ALT_L};
    mmd_data_t e[8] = '{8'h91, 8'hA0, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97, 8'h98};
    for (int i = 0; i < 8; i++)
    begin
      wr(a[i], 8'h00);
      rc(a[i], e[i]);
    end
  endtask
  task automatic t_mid_reset;
    wr(OFS_PB_DIR, 8'hFF);
    wr(OFS_PA_DIR, 8'hFF);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rc(OFS_PA_DIR, 8'h00);
    rc(OFS_PB_DIR, 8'h00);
  endtask
  task automatic t_ram;
    wr(RAM_LO, 8'h5A);
    wr(RAM_HI, 8'hA5);
    wr(STACK_BOT, 8'h3C);
    wr(STACK_TOP, 8'hC3);
    wr(13'h0130, 8'h77);
    rc(13'h0130, UNDEF_B);
    rc(13'h007F, UNDEF_B);
  endtask
  // Boundaries of the ROM and stack regions plus RAM base and 0x13FF, reads checked for select lines and data
  task automatic t_map;
    mmd_addr_t a[10] = '{13'h1400, 13'h1DFF, 13'h1E00, 13'h1FEF, 13'h1FF0, 13'h1FFF, 13'h13FF, 13'h00C0,
      13'h00FF, 13'h0080};
    logic [3:0] s[10] = '{4'h8, 4'h8, 4'h2, 4'h2, 4'h4, 4'h4, 4'h0, 4'h1, 4'h1, 4'h0};
    mmd_data_t dd[10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3C, 8'hC3, 8'h5A};
    for (int i = 0; i < 10; i++)
    begin
      if (s[i][3:1] != 3'b000)
        dd[i] = a[i][7:0] ^ {3'h5, a[i][12:8]};
      rc(a[i], dd[i]);
      chk({usr, vec, sck, stk}, s[i], "selects");
    end
  endtask
  task automatic t_unused;
    wr(13'h0003, 8'hFF);
    rc(13'h0003, UNDEF_B);
    wr(OFS_PA_PULL, 8'hAA);
    chk(regs.pa_pull, 8'hAA, "pull stored");
    rc(OFS_PA_PULL, UNDEF_B);
    wr(OFS_MFT_CNT, 8'hFF);
    rc(OFS_MFT_CNT, 8'h91);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    rst = 1'b1;
    cpu_addr = '0;
    cpu_rd = 1'b0;
    cpu_wr = 1'b0;
    cpu_wdata = '0;
    pa_pins = 8'h00;
    pbc_pins = 8'h00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset_dirs;
    t_ports;
    t_flags;
    t_ram;
    t_map;
    t_unused;
    t_periph;
    t_mid_reset;
    tally_and_finish;
  end
  // Whole run needs about 130 cycles
  initial
  begin
    repeat (2000) @(posedge clk);
    n_mismatch++;
    tally_and_finish;
  end
endmodule
